// file: rtl/lcd_led_scan_pkg.sv
/*
 * Constants, register map and field layout for the display scan timing block.
 * Assumes a 32-bit APB master, one register per aligned word, byte address = index * 4.
 */
// Contract
// - Mode register top bit picks dot-matrix scanning when set, row-column when clear.
// - Clock field: 1x picks 1MHz RC, 01 crystal, 00 slow 32kHz RC.
// - Charge window field gives 1/8, 1/16, 1/32, 1/64 of a common slot.
// - Bias network bit picks low-value network when clear, high-value when set; driven out.
// - Bias mode: 00 slow only, 01 fast only, 1x automatic fast/slow switching.
// - Row-column slot lasts (width+1)*16us; same value is dot-matrix first on-time.
// - Dot-matrix group scan time is the larger of both on-times.
// - LCD slot lasts (width+1)*64us; top two width bits ignored.
// - LCD width applies only on 1MHz RC; other clocks keep frames at 64Hz or faster.
// - Dot-matrix second on-time is (value+1)*16us.
// - In 4x4 mode the invert bit makes a selected common drive high, else low.
// - 4x4 mode: lines 0-3 are common selects, lines 4-7 segment selects.
// - Contrast enable bit turns the contrast regulator on or off; driven out.
// - Four-bit contrast level passes to the regulator, higher code higher voltage.
// - Display type bit clear enables LCD driver, set enables LED driver.
// - Scan run bit starts scanning when set, stops it when cleared.
// - Repeat bit set scans continuously, clear stops after each frame.
// - Scan flags clear on a zero write or on any scan run register write.
package lcd_led_scan_pkg;

    localparam int         ADDR_W        = 12;
    // Printed indexes; byte address is four times the index
    localparam logic [7:0] MODE_IDX      = 8'hB2;
    localparam logic [7:0] WIDTH_IDX     = 8'hB3;
    localparam logic [7:0] SECOND_IDX    = 8'hB4;
    localparam logic [7:0] CON1_IDX      = 8'hB9;
    localparam logic [7:0] FLAGS_IDX     = 8'hAE;
    localparam logic [7:0] RUN_IDX       = 8'hAF;
    localparam logic [7:0] CTRL_IDX      = 8'hB1;

    // Display mode register fields
    localparam int MODE_DOT_BIT   = 7;
    localparam int MODE_SRC_LSB   = 5;
    localparam int MODE_RSEL_BIT  = 4;
    localparam int MODE_FC_LSB    = 2;
    localparam int MODE_RMOD_LSB  = 0;
    // Contrast / matrix register fields
    localparam int CON1_INV_BIT   = 6;
    localparam int CON1_MAT_BIT   = 5;
    localparam int CON1_PWR_BIT   = 4;
    localparam int CON1_VOL_LSB   = 0;
    // Control register fields
    localparam int CTRL_TYPE_BIT  = 2;
    localparam int CTRL_REP_BIT   = 1;
    // Flag register fields
    localparam int FLAG_LED_BIT   = 0;
    localparam int FLAG_LCD_BIT   = 1;

    localparam logic [7:0] RESET_VAL = 8'h00;

    // Clock source codes and sampled clock lanes
    localparam logic [1:0] SRC_SLOW  = 2'b00;
    localparam logic [1:0] SRC_XTAL  = 2'b01;
    localparam int LANE_ONE_MHZ_RC = 0;
    localparam int LANE_XTAL = 1;
    localparam int LANE_SLOW = 2;

    // Bias drive modes
    localparam logic [1:0] RMOD_SLOW = 2'b00;
    localparam logic [1:0] RMOD_FAST = 2'b01;

    // Timing, counted in display clock edges
    localparam int ONE_MHZ_RC_PERIOD_NS  = 1000;
    localparam int LED_UNIT_NS     = 16000;
    localparam int LCD_UNIT_NS     = 64000;
    localparam int LED_UNIT_EDGES  = LED_UNIT_NS / ONE_MHZ_RC_PERIOD_NS;
    localparam int LCD_UNIT_EDGES  = LCD_UNIT_NS / ONE_MHZ_RC_PERIOD_NS;
    localparam int SLOW_CLK_HZ     = 32768;
    localparam int FRAME_MIN_HZ    = 64;
    localparam int CHARGE_BASE_SH  = 3;

endpackage

// file: rtl/edge_sync.sv
/*
 * Two-flop synchroniser with rising edge detect for a group of slow clocks.
 * Assumes inputs are far slower than sys_clk so no edge is missed.
 */
`timescale 1ns/1ps
module edge_sync #(
    parameter int W = 3
) (
    input  wire logic         sys_clk,  // System clock
    input  wire logic         reset,    // Synchronous reset, active high
    input  wire logic [W-1:0] async_in, // Asynchronous levels
    output logic      [W-1:0] rise      // One-cycle pulse per rising edge
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Edge seen on synchronised copy only
    assign rise = s_q.sync & ~s_q.prev;
endmodule

// file: rtl/lcd_led_scan_timing.sv
/*
 * Scan timing, mode control and APB register file for a segment LCD / LED matrix driver.
 * Assumes a zero-wait APB master on sys_clk and free-running display clocks on pins.
 */
`timescale 1ns/1ps
module lcd_led_scan_timing
    import lcd_led_scan_pkg::*;
#(
    parameter int NUM_COMS = 8
) (
    input  wire logic              sys_clk,               // 250 MHz system clock
    input  wire logic              reset,                 // Synchronous reset, active high
    input  wire logic              psel,                  // APB select
    input  wire logic              penable,               // APB access phase
    input  wire logic              pwrite,                // APB write
    input  wire logic [ADDR_W-1:0] paddr,                 // APB byte address
    input  wire logic [31:0]       pwdata,                // APB write data
    output logic      [31:0]       prdata,                // APB read data
    output logic                   pready,                // APB ready
    output logic                   pslverr,               // APB error, unmapped address
    input  wire logic              one_mhz_rc,            // 1MHz RC clock pin
    input  wire logic              xtal_clk,              // Crystal clock pin
    input  wire logic              slow_internal_rc,      // 32kHz RC clock pin
    input  wire logic [3:0]        seg_pattern,           // 4x4 segment data
    output logic      [7:0]        common_sel,            // One-hot active common
    output logic      [7:0]        led_line,              // LED line drive
    output logic                   scanning,              // Scan active
    output logic                   lcd_drive_en,          // LCD driver enabled
    output logic                   led_drive_en,          // LED driver enabled
    output logic                   dot_matrix_mode,       // Serial dot-matrix style
    output logic      [1:0]        glass_clock_source,    // Selected LCD clock code
    output logic                   charge_active,         // Inside charge window
    output logic                   bias_fast_en,          // Fast bias network on
    output logic                   bias_slow_en,          // Slow bias network on
    output logic                   bias_network_sel,      // High-value slow network
    output logic                   contrast_regulator_on, // Contrast regulator enable
    output logic      [3:0]        contrast_level,        // Contrast code
    output logic                   glass_irq_flag,        // LCD frame flag
    output logic                   led_irq_flag           // LED frame flag
);
    localparam int FIXED_SLOT_EDGES = SLOW_CLK_HZ / (FRAME_MIN_HZ * NUM_COMS);

    localparam logic [ADDR_W-1:0] MODE_ADDR   = ADDR_W'(MODE_IDX * 4);
    localparam logic [ADDR_W-1:0] WIDTH_ADDR  = ADDR_W'(WIDTH_IDX * 4);
    localparam logic [ADDR_W-1:0] SECOND_ADDR = ADDR_W'(SECOND_IDX * 4);
    localparam logic [ADDR_W-1:0] CON1_ADDR   = ADDR_W'(CON1_IDX * 4);
    localparam logic [ADDR_W-1:0] FLAGS_ADDR  = ADDR_W'(FLAGS_IDX * 4);
    localparam logic [ADDR_W-1:0] RUN_ADDR    = ADDR_W'(RUN_IDX * 4);
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = ADDR_W'(CTRL_IDX * 4);
    localparam logic [2:0]        LAST_COM    = 3'(NUM_COMS - 1);

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  width;
        logic [7:0]  second;
        logic [6:0]  con1;
        logic [2:0]  ctrl;
        logic        run;
        logic [1:0]  flags;
        logic        halted;
        logic [2:0]  com;
        logic [15:0] elapsed;
        logic [7:0]  common;
        logic [7:0]  line;
        logic        charge;
        logic        fast;
        logic        slow;
    } state_s;

    state_s      s_q;
    state_s      s_d;
    logic [2:0]  rise;
    logic        wr_en;
    logic        active;
    logic        is_lcd;
    logic        base_edge;
    logic        slot_end;
    logic        frame_end;
    logic        restart;
    logic        charge_now;
    logic [15:0] slot_len;
    logic [7:0]  onehot;

    // Larger of two on-time values
    function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction

    // Slot length in display clock edges for the current mode
    function automatic logic [15:0] slot_edges(input logic lcd, input logic dot,
                                               input logic [1:0] src, input logic [7:0] w,
                                               input logic [7:0] sec);
        logic [15:0] n;
        n = 16'h0000;
        if (lcd) begin
            if (src[1]) begin
                n = 16'({10'h000, w[5:0]} + 16'h0001) * 16'(LCD_UNIT_EDGES);
            end else begin
                n = 16'(FIXED_SLOT_EDGES);
            end
        end else if (dot) begin
            n = 16'({8'h00, max8(w, sec)} + 16'h0001) * 16'(LED_UNIT_EDGES);
        end else begin
            n = 16'({8'h00, w} + 16'h0001) * 16'(LED_UNIT_EDGES);
        end
        return n;
    endfunction

    edge_sync #(
        .W (3)
    ) u_clk_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({slow_internal_rc, xtal_clk, one_mhz_rc}),
        .rise     (rise)
    );

    // APB decode; zero wait states, so a request ends in its first access cycle
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            MODE_ADDR:   prdata = {24'h000000, s_q.mode};
            WIDTH_ADDR:  prdata = {24'h000000, s_q.width};
            SECOND_ADDR: prdata = {24'h000000, s_q.second};
            CON1_ADDR:   prdata = {25'h0000000, s_q.con1};
            FLAGS_ADDR:  prdata = {30'h00000000, s_q.flags};
            RUN_ADDR:    prdata = {31'h00000000, s_q.run};
            CTRL_ADDR:   prdata = {29'h00000000, s_q.ctrl};
            default:     pslverr = psel && penable;
        endcase
    end

    // Scan timing terms
    assign active    = s_q.run && !s_q.halted;
    assign restart   = wr_en && (paddr == RUN_ADDR);
    assign is_lcd    = !s_q.ctrl[CTRL_TYPE_BIT];
    assign slot_len  = slot_edges(is_lcd, s_q.mode[MODE_DOT_BIT],
                                  s_q.mode[MODE_SRC_LSB +: 2], s_q.width, s_q.second);
    always_comb begin
        base_edge = rise[LANE_ONE_MHZ_RC];
        if (is_lcd) begin
            if (s_q.mode[MODE_SRC_LSB + 1]) begin
                base_edge = rise[LANE_ONE_MHZ_RC];
            end else if (s_q.mode[MODE_SRC_LSB +: 2] == SRC_XTAL) begin
                base_edge = rise[LANE_XTAL];
            end else begin
                base_edge = rise[LANE_SLOW];
            end
        end
    end
    // >= guards against a slot shortened by software mid-count
    assign slot_end   = active && base_edge && !restart
        && ((s_q.elapsed + 16'h0001) >= slot_len);
    assign frame_end  = slot_end && (s_q.com == LAST_COM);
    assign charge_now = active
        && (s_q.elapsed < (slot_len >> (CHARGE_BASE_SH + s_q.mode[MODE_FC_LSB +: 2])));
    assign onehot     = 8'h01 << s_q.com;

    // Next state: registers, scan counters and registered pin drive
    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            unique case (paddr)
                MODE_ADDR:   s_d.mode   = pwdata[7:0];
                WIDTH_ADDR:  s_d.width  = pwdata[7:0];
                SECOND_ADDR: s_d.second = pwdata[7:0];
                CON1_ADDR:   s_d.con1   = pwdata[6:0];
                CTRL_ADDR:   s_d.ctrl   = pwdata[2:0];
                FLAGS_ADDR:  s_d.flags  = s_q.flags & pwdata[1:0];
                RUN_ADDR: begin
                    s_d.run    = pwdata[0];
                    s_d.flags  = 2'b00;
                    s_d.halted = 1'b0;
                    s_d.com    = 3'h0;
                end
                default: ;
            endcase
        end
        // Counters restart when scanning is off or a run write restarts it
        if (!active || restart) begin
            s_d.elapsed = 16'h0000;
            s_d.com     = 3'h0;
        end else if (slot_end) begin
            s_d.elapsed = 16'h0000;
            s_d.com     = (s_q.com == LAST_COM) ? 3'h0 : s_q.com + 3'h1;
        end else if (base_edge) begin
            s_d.elapsed = s_q.elapsed + 16'h0001;
        end
        // Frame flags: set wins over a zero-write clear in the same cycle; a run write blocks the frame end
        if (frame_end) begin
            if (is_lcd) begin
                s_d.flags[FLAG_LCD_BIT] = 1'b1;
            end else begin
                s_d.flags[FLAG_LED_BIT] = 1'b1;
            end
            if (!s_q.ctrl[CTRL_REP_BIT]) begin
                s_d.halted = 1'b1;
            end
        end
        // Pin drive, one cycle behind the counters
        s_d.common = active ? onehot : 8'h00;
        if (s_q.con1[CON1_MAT_BIT]) begin
            s_d.line[3:0] = (active ? onehot[3:0] ^ onehot[7:4] : 4'h0)
                ^ {4{!s_q.con1[CON1_INV_BIT]}};
            s_d.line[7:4] = active ? seg_pattern : 4'h0;
        end else begin
            s_d.line = (active && !is_lcd) ? onehot : 8'h00;
        end
        s_d.charge = charge_now;
        unique case (s_q.mode[MODE_RMOD_LSB +: 2])
            RMOD_SLOW: begin
                s_d.fast = 1'b0;
                s_d.slow = 1'b1;
            end
            RMOD_FAST: begin
                s_d.fast = 1'b1;
                s_d.slow = 1'b0;
            end
            default: begin
                s_d.fast = charge_now;
                s_d.slow = !charge_now;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Register-fed outputs
    assign common_sel            = s_q.common;
    assign led_line              = s_q.line;
    assign scanning              = active;
    assign lcd_drive_en          = active && is_lcd;
    assign led_drive_en          = active && !is_lcd;
    assign dot_matrix_mode       = s_q.mode[MODE_DOT_BIT];
    assign glass_clock_source    = s_q.mode[MODE_SRC_LSB +: 2];
    assign charge_active         = s_q.charge;
    assign bias_fast_en          = s_q.fast;
    assign bias_slow_en          = s_q.slow;
    assign bias_network_sel      = s_q.mode[MODE_RSEL_BIT];
    assign contrast_regulator_on = s_q.con1[CON1_PWR_BIT];
    assign contrast_level        = s_q.con1[CON1_VOL_LSB +: 4];
    assign glass_irq_flag        = s_q.flags[FLAG_LCD_BIT];
    assign led_irq_flag          = s_q.flags[FLAG_LED_BIT];

    // Checks on scan timing, bias drive, flags and register-fed outputs
    sequence s_write(logic [ADDR_W-1:0] a);
        wr_en && (paddr == a);
    endsequence

    sequence s_run_off;
        !active;
    endsequence

    property p_stop_idle;
        @(posedge sys_clk) disable iff (reset) s_run_off ##1 s_run_off |-> common_sel == 8'h00;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("common active while stopped");

    property p_type_excl;
        @(posedge sys_clk) disable iff (reset) !(lcd_drive_en && led_drive_en);
    endproperty
    a_type_excl: assert property (p_type_excl) else $error("both drivers on");

    property p_rsel;
        @(posedge sys_clk) disable iff (reset)
            s_write(MODE_ADDR) |=> bias_network_sel == $past(pwdata[MODE_RSEL_BIT]);
    endproperty
    a_rsel: assert property (p_rsel) else $error("bias network select wrong");

    property p_fast_only;
        @(posedge sys_clk) disable iff (reset)
            (s_q.mode[1:0] == RMOD_FAST) ##1 (s_q.mode[1:0] == RMOD_FAST)
            |-> bias_fast_en && !bias_slow_en;
    endproperty
    a_fast_only: assert property (p_fast_only) else $error("fast mode not fast");

    property p_auto_bias;
        @(posedge sys_clk) disable iff (reset)
            s_q.mode[1] |=> (bias_fast_en == $past(charge_now)) && (bias_slow_en != bias_fast_en);
    endproperty
    a_auto_bias: assert property (p_auto_bias) else $error("auto bias mismatch");

    property p_flag_set;
        @(posedge sys_clk) disable iff (reset)
            frame_end && is_lcd |=> glass_irq_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("frame flag lost");

    property p_run_clear;
        @(posedge sys_clk) disable iff (reset)
            s_write(RUN_ADDR) |=> !glass_irq_flag && !led_irq_flag;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("flags not cleared");

    property p_one_shot;
        @(posedge sys_clk) disable iff (reset)
            frame_end && !s_q.ctrl[CTRL_REP_BIT] |=> !scanning [*2];
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("single frame kept scanning");

    property p_slot_reload;
        @(posedge sys_clk) disable iff (reset)
            slot_end |=> (s_q.elapsed == 16'h0000) && (s_q.com != $past(s_q.com) || !active);
    endproperty
    a_slot_reload: assert property (p_slot_reload) else $error("slot not reloaded");

    property p_lcd_fixed;
        @(posedge sys_clk) disable iff (reset)
            active && is_lcd && !s_q.mode[MODE_SRC_LSB + 1] |-> slot_len == 16'(FIXED_SLOT_EDGES);
    endproperty
    a_lcd_fixed: assert property (p_lcd_fixed) else $error("slow LCD slot wrong");

    property p_matrix_pol;
        @(posedge sys_clk) disable iff (reset)
            active && s_q.con1[CON1_MAT_BIT] && s_q.con1[CON1_INV_BIT] |=> $onehot(led_line[3:0]);
    endproperty
    a_matrix_pol: assert property (p_matrix_pol) else $error("4x4 common drive wrong");

    property p_contrast;
        @(posedge sys_clk) disable iff (reset)
            s_write(CON1_ADDR) |=> contrast_regulator_on == $past(pwdata[CON1_PWR_BIT])
                && contrast_level == $past(pwdata[3:0]);
    endproperty
    a_contrast: assert property (p_contrast) else $error("contrast not applied");
endmodule

// file: dv/glass_model.sv
/*
 * Behavioural stand-in for the LCD glass / LED array on the common and segment pins.
 * Assumes common_sel and charge_active are registered outputs on sys_clk.
 */
`timescale 1ns/1ps
module glass_model (
    input  wire logic       sys_clk,       // System clock
    input  wire logic [7:0] common_sel,    // Active common from the driver
    input  wire logic       charge_active, // Charge window from the driver
    output logic      [3:0] seg_pattern,   // Segment data fed back in 4x4 mode
    output int              slot_cyc,      // Length of the last finished slot
    output int              chg_cyc,       // Length of the last charge window
    output int              slots          // Count of common changes seen
);
    int         run_c = 0;
    int         chg_c = 0;
    logic [7:0] com_q;
    logic       chg_q = 1'b0;

    initial seg_pattern = 4'h0;

    // Measure slot and charge lengths in sys cycles; segment data moves with each common
    always @(posedge sys_clk) begin
        com_q <= common_sel;
        chg_q <= charge_active;
        seg_pattern <= common_sel[3:0] ^ common_sel[7:4] ^ 4'h9;
        if (common_sel !== com_q) begin
            slot_cyc <= run_c;
            slots <= slots + 1;
            run_c <= 1;
        end else begin
            run_c <= run_c + 1;
        end
        if (charge_active === 1'b1)
            chg_c <= chg_q ? chg_c + 1 : 1;
        if (chg_q === 1'b1 && charge_active !== 1'b1)
            chg_cyc <= chg_c;
    end
endmodule

// file: dv/lcd_led_scan_timing_bench.sv
/*
 * Self-checking bench for the display scan timing block over APB.
 * Assumes display clocks run fast stand-ins, so slots are counted in their edges.
 */
`timescale 1ns/1ps
module lcd_led_scan_timing_bench;
    import lcd_led_scan_pkg::*;
    localparam int RC_CYC = 10; // Shortened stand-in periods, in sys cycles
    localparam int XT_CYC = 12;
    localparam int SL_CYC = 14;
    logic              sys_clk = 1'b0;
    logic              reset = 1'b1;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata;
    logic              pready, pslverr, scanning, lcd_drive_en, led_drive_en;
    logic              one_mhz_rc = 1'b0, xtal_clk = 1'b0, slow_internal_rc = 1'b0;
    logic [3:0]        seg_pattern, contrast_level;
    logic [7:0]        common_sel, led_line;
    logic [1:0]        glass_clock_source;
    logic              dot_matrix_mode, charge_active, bias_fast_en, bias_slow_en;
    logic              bias_network_sel, contrast_regulator_on, glass_irq_flag, led_irq_flag;
    int                num_errors = 0, n_compared = 0, cyc = 0;

    // Clocks; phases chosen so no display edge meets a sys_clk rising edge
    always #2 sys_clk = ~sys_clk;
    always #(RC_CYC * 2) one_mhz_rc = ~one_mhz_rc;
    always #(XT_CYC * 2) xtal_clk = ~xtal_clk;
    always #(SL_CYC * 2) slow_internal_rc = ~slow_internal_rc;

    lcd_led_scan_timing #(.NUM_COMS(8)) u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .one_mhz_rc(one_mhz_rc), .xtal_clk(xtal_clk),
        .slow_internal_rc(slow_internal_rc), .seg_pattern(seg_pattern),
        .common_sel(common_sel), .led_line(led_line), .scanning(scanning),
        .lcd_drive_en(lcd_drive_en), .led_drive_en(led_drive_en),
        .dot_matrix_mode(dot_matrix_mode), .glass_clock_source(glass_clock_source),
        .charge_active(charge_active), .bias_fast_en(bias_fast_en),
        .bias_slow_en(bias_slow_en), .bias_network_sel(bias_network_sel),
        .contrast_regulator_on(contrast_regulator_on), .contrast_level(contrast_level),
        .glass_irq_flag(glass_irq_flag), .led_irq_flag(led_irq_flag));

    glass_model u_gm (.sys_clk(sys_clk), .common_sel(common_sel), .charge_active(charge_active),
        .seg_pattern(seg_pattern), .slot_cyc(), .chg_cyc(), .slots());

    task automatic print_verdict();
        $display("compared=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, {24'h0, d}, r, e);
        @(posedge sys_clk); // Let register outputs settle
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic start(input logic [7:0] ct, input logic [7:0] md, input logic [7:0] wd,
                         input logic [7:0] sc);
        wr(CTRL_IDX, ct);
        wr(MODE_IDX, md);
        wr(WIDTH_IDX, wd);
        wr(SECOND_IDX, sc);
        wr(RUN_IDX, 8'h01);
    endtask

    // Fourth change after a restart always closes a whole slot
    task automatic slot(input int edges, input int per);
        repeat (4) @(u_gm.slots);
        chk(u_gm.slot_cyc, edges * per);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd(MODE_IDX, 32'h0);
        rd(WIDTH_IDX, 32'h0);
        rd(SECOND_IDX, 32'h0);
        rd(CON1_IDX, 32'h0);
        wr(MODE_IDX, 8'hB5);
        chk({dot_matrix_mode, glass_clock_source, bias_network_sel}, 4'hB);
        wr(MODE_IDX, 8'h4A);
        chk({dot_matrix_mode, glass_clock_source, bias_network_sel}, 4'h4);
        rd(MODE_IDX, 32'h4A);
        wr(WIDTH_IDX, 8'h5A);
        rd(WIDTH_IDX, 32'h5A);
        wr(SECOND_IDX, 8'hC3);
        rd(SECOND_IDX, 32'hC3);
        apb(1'b1, 8'h00, 32'hFF, r, e);
        chk(e, 1'b1);
        chk(pready, 1'b1);
        apb(1'b0, 8'h00, 32'h0, r, e);
        chk({e, r}, {1'b1, 32'h0});
        for (int v = 0; v < 16; v++) begin
            wr(CON1_IDX, 8'h10 | v[7:0]);
            chk({contrast_regulator_on, contrast_level}, {1'b1, v[3:0]});
        end
        wr(CON1_IDX, 8'h0F);
        chk(contrast_regulator_on, 1'b0);
    endtask

    task automatic t_scan();
        logic [7:0] w [2] = '{8'h01, 8'h04};
        logic [7:0] s [2] = '{8'h03, 8'h02};
        start(8'h06, 8'h00, 8'h02, 8'h00);
        chk({scanning, led_drive_en, lcd_drive_en}, 3'b110);
        slot(48, RC_CYC);
        for (int i = 0; i < 2; i++) begin
            start(8'h06, 8'h80, w[i], s[i]);
            slot(i == 0 ? 64 : 80, RC_CYC);
        end
        start(8'h02, 8'h60, 8'hC1, 8'h00);
        chk({lcd_drive_en, led_drive_en}, 2'b10);
        slot(128, RC_CYC);
        start(8'h02, 8'h20, 8'hC1, 8'h00);
        slot(64, XT_CYC);
        start(8'h02, 8'h00, 8'hC1, 8'h00);
        slot(64, SL_CYC);
    endtask

    // Each charge code paired with a bias mode, so all four of each are set
    task automatic t_charge();
        for (int f = 0; f < 4; f++) begin
            start(8'h02, 8'h40 | f[7:0] << 2 | f[7:0], 8'h00, 8'h00);
            repeat (4) @(u_gm.slots);
            chk(u_gm.chg_cyc, (64 >> (3 + f)) * RC_CYC);
            while (charge_active !== 1'b1)
                @(posedge sys_clk);
            repeat (2) @(posedge sys_clk);
            chk({bias_fast_en, bias_slow_en}, f == 0 ? 2'b01 : 2'b10);
            while (charge_active !== 1'b0)
                @(posedge sys_clk);
            repeat (2) @(posedge sys_clk);
            chk({bias_fast_en, bias_slow_en}, f == 1 ? 2'b10 : 2'b01);
        end
    endtask

    task automatic t_matrix();
        logic [3:0] oh;
        for (int i = 0; i < 2; i++) begin
            wr(CON1_IDX, i ? 8'h60 : 8'h20);
            start(8'h06, 8'h00, 8'h00, 8'h00);
            repeat (2) @(u_gm.slots);
            repeat (3) @(posedge sys_clk);
            oh = common_sel[3:0] | common_sel[7:4];
            chk(led_line, {seg_pattern, i ? oh : ~oh});
        end
        wr(CON1_IDX, 8'h00);
    endtask

    // Single frame stops and raises a flag; flags clear by zero write or run write
    task automatic t_once();
        start(8'h04, 8'h00, 8'h00, 8'h00);
        while (scanning === 1'b1)
            @(posedge sys_clk);
        @(posedge sys_clk); // Pins drop a cycle after the halt
        chk({led_irq_flag, glass_irq_flag, common_sel}, 10'h200);
        wr(FLAGS_IDX, 8'h02);
        chk(led_irq_flag, 1'b0);
        start(8'h00, 8'h60, 8'h00, 8'h00);
        while (scanning === 1'b1)
            @(posedge sys_clk);
        chk({glass_irq_flag, led_irq_flag}, 2'b10);
        wr(RUN_IDX, 8'h00);
        chk({glass_irq_flag, scanning}, 2'b00);
    endtask

    // Hang guard, well above the expected run length
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        $display("test regs done");
        t_scan();
        $display("test scan done");
        t_charge();
        $display("test charge done");
        t_matrix();
        $display("test matrix done");
        t_once();
        $display("test once done");
        print_verdict();
    end
endmodule
